// ---- dpc_top.sv ----
// Playback path control: interrupts, coefficient boot load, mixer select
// and headphone analog volume with soft-stepping.
// Assumes event and sample inputs come from logic on mclk.
module dpc_top
  import dpc_pkg::*;
#(
  parameter int LOAD_CYCLES = DPC_LOAD_CYC
)
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Paged register port.
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Fault and overflow events, one-cycle pulses.
  input wire logic hp_overcurrent,
  input wire logic spk_overcurrent,
  input wire logic dac_overflow,
  input wire logic filter_overflow,
  // Converter state and samples.
  input wire logic dac_power,
  input wire logic sample_tick,
  input wire logic [23:0] left_sample,
  input wire logic [23:0] right_sample,
  output logic [23:0] mono_sample,
  // Coefficient read port for the filter engine.
  input wire logic [4:0] coef_idx,
  output logic [23:0] coef_data,
  output logic coeff_loading,
  // Interrupts and pin.
  output logic first_host_irq,
  output logic second_host_irq,
  output logic gpio_out,
  // Headphone analog volume.
  output logic [6:0] hp_vol_code,
  output logic [9:0] hp_atten_tenths,
  output logic hp_mute,
  output logic hp_mix_route
);

  //////////////////////////////////////////////////////////////////////////
  // Declarations.
  logic [7:0] page_r, irq1_cfg_r, irq2_cfg_r, gpio_ctrl_r, path_r;
  logic [7:0] hp_route_r, hp_vol_r, coef_ctrl_r, flags_a_r, flags_b_r;
  logic [7:0] rdata_nxt;
  logic soft_rst_r;
  logic pg_ctrl, pg_analog, pg_coef, wr0, wr1, rd0;
  logic [3:0] lat;
  logic pend1, pend2;
  dpc_ld_t ld_r;
  logic [4:0] ld_idx_r;
  logic [15:0] ld_tmr_r;
  logic [23:0] coef_mem [0:DPC_NCOEF-1];
  logic [6:0] coef_off;
  logic [4:0] coef_sel;
  logic coef_hit, coef_wr_ok;
  logic [24:0] mix_sum;
  logic [11:0] osc_cnt_r;
  logic osc_tick, step_src, half_r, step_en;
  logic [6:0] vol_tgt;

  assign pg_ctrl = (page_r == DPC_PG_CTRL);
  assign pg_analog = (page_r == DPC_PG_ANALOG);
  assign pg_coef = (page_r >= DPC_PG_COEF_LO) && (page_r <= DPC_PG_COEF_HI);
  assign wr0 = reg_wr & pg_ctrl;
  assign wr1 = reg_wr & pg_analog;
  assign rd0 = reg_rd & pg_ctrl;

  //////////////////////////////////////////////////////////////////////////
  // Page select lives at offset 0 of every page.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      page_r <= DPC_RST_REG;
    end else if (soft_rst_r) begin
      page_r <= DPC_RST_REG;
    end else if (reg_wr && reg_addr == DPC_A_PAGE) begin
      page_r <= reg_wdata;
    end
  end

  // Software reset is a self-clearing one-cycle strobe.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= wr0 && reg_addr == DPC_A_SWRST && reg_wdata[DPC_B_SWRST];
    end
  end

  // Control registers written by the host.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq1_cfg_r <= DPC_RST_REG;
      irq2_cfg_r <= DPC_RST_REG;
      gpio_ctrl_r <= DPC_RST_REG;
      path_r <= DPC_RST_REG;
      hp_route_r <= DPC_RST_REG;
      hp_vol_r <= DPC_RST_REG;
      coef_ctrl_r <= DPC_RST_REG;
    end else if (soft_rst_r) begin
      irq1_cfg_r <= DPC_RST_REG;
      irq2_cfg_r <= DPC_RST_REG;
      gpio_ctrl_r <= DPC_RST_REG;
      path_r <= DPC_RST_REG;
      hp_route_r <= DPC_RST_REG;
      hp_vol_r <= DPC_RST_REG;
      coef_ctrl_r <= DPC_RST_REG;
    end else begin
      if (wr0 && reg_addr == DPC_A_IRQ1_CFG) irq1_cfg_r <= reg_wdata;
      if (wr0 && reg_addr == DPC_A_IRQ2_CFG) irq2_cfg_r <= reg_wdata;
      if (wr0 && reg_addr == DPC_A_GPIO_CTRL) gpio_ctrl_r <= reg_wdata;
      if (wr0 && reg_addr == DPC_A_PATH_SETUP) path_r <= reg_wdata;
      if (wr1 && reg_addr == DPC_A_HP_ROUTE) hp_route_r <= reg_wdata;
      if (wr1 && reg_addr == DPC_A_HP_VOL) hp_vol_r <= reg_wdata;
      if (reg_wr && pg_coef && reg_addr == DPC_A_COEF_CTRL) begin
        coef_ctrl_r <= reg_wdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Sticky event flags. A read clears them, but an event in the same
  // cycle as the read survives so that no fault is lost.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flags_a_r <= 8'h00;
      flags_b_r <= 8'h00;
    end else if (soft_rst_r) begin
      flags_a_r <= 8'h00;
      flags_b_r <= 8'h00;
    end else begin
      if (rd0 && reg_addr == DPC_A_FLAGS_A) flags_a_r <= 8'h00;
      if (rd0 && reg_addr == DPC_A_FLAGS_B) flags_b_r <= 8'h00;
      if (spk_overcurrent) flags_a_r[DPC_B_FL_SPK_OC] <= 1'b1;
      if (hp_overcurrent) flags_a_r[DPC_B_FL_HP_OC] <= 1'b1;
      if (dac_overflow) flags_b_r[DPC_B_FL_DAC_OVF] <= 1'b1;
      if (filter_overflow) flags_b_r[DPC_B_FL_FLT_OVF] <= 1'b1;
    end
  end

  // Latched events in enable-bit order: hp, spk, dac, filter.
  assign lat = {flags_a_r[DPC_B_FL_HP_OC], flags_a_r[DPC_B_FL_SPK_OC],
                flags_b_r[DPC_B_FL_DAC_OVF], flags_b_r[DPC_B_FL_FLT_OVF]};
  assign pend1 = |(lat & irq1_cfg_r[DPC_B_EN_HP_OC:DPC_B_EN_FLT_OVF]);
  assign pend2 = |(lat & irq2_cfg_r[DPC_B_EN_HP_OC:DPC_B_EN_FLT_OVF]);

  // One pulse generator per interrupt output.
  dpc_irq_gen u_irq1 (
    .mclk(mclk),
    .rst_n(rst_n),
    .train_mode(irq1_cfg_r[DPC_B_TRAIN]),
    .pending(pend1),
    .irq(first_host_irq)
  );

  dpc_irq_gen u_irq2 (
    .mclk(mclk),
    .rst_n(rst_n),
    .train_mode(irq2_cfg_r[DPC_B_TRAIN]),
    .pending(pend2),
    .irq(second_host_irq)
  );

  // The pin follows the selected interrupt, one flop behind it.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gpio_out <= 1'b0;
    end else begin
      unique case (gpio_ctrl_r[1:0])
        DPC_GPIO_LOW: gpio_out <= 1'b0;
        DPC_GPIO_IRQ1: gpio_out <= first_host_irq;
        DPC_GPIO_IRQ2: gpio_out <= second_host_irq;
        default: gpio_out <= 1'b1;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Boot loader: copy defaults one entry per cycle, then hold the window
  // closed until the full load time has run.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ld_r <= DPC_LD_COPY;
      ld_idx_r <= 5'h00;
      ld_tmr_r <= 16'h0000;
    end else if (soft_rst_r) begin
      ld_r <= DPC_LD_COPY;
      ld_idx_r <= 5'h00;
      ld_tmr_r <= 16'h0000;
    end else begin
      if (ld_r != DPC_LD_IDLE) ld_tmr_r <= ld_tmr_r + 16'h0001;
      unique case (ld_r)
        DPC_LD_COPY: begin
          ld_idx_r <= ld_idx_r + 5'h01;
          if (ld_idx_r == 5'(DPC_NCOEF - 1)) ld_r <= DPC_LD_WAIT;
        end
        DPC_LD_WAIT: begin
          if (ld_tmr_r >= 16'(LOAD_CYCLES - 1)) ld_r <= DPC_LD_IDLE;
        end
        DPC_LD_IDLE: begin
          ld_r <= DPC_LD_IDLE;
        end
      endcase
    end
  end

  assign coeff_loading = (ld_r != DPC_LD_IDLE);

  // Host access decode. Each coefficient is a 4-byte slot, MSB first.
  assign coef_off = reg_addr - DPC_A_COEF_BASE;
  assign coef_sel = coef_off[6:2];
  assign coef_hit = pg_coef && (page_r == DPC_PG_COEF_LO) && !coeff_loading &&
                    (reg_addr >= DPC_A_COEF_BASE) &&
                    (coef_sel < 5'(DPC_NCOEF));
  // Writes while the DAC runs need adaptive mode.
  assign coef_wr_ok = coef_hit && reg_wr &&
                      (!dac_power || coef_ctrl_r[DPC_B_ADAPTIVE]);

  // Coefficient storage, one entry per generate step.
  for (genvar i = 0; i < DPC_NCOEF; i++) begin : g_coef
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        coef_mem[i] <= DPC_COEF_ZERO;
      end else if (ld_r == DPC_LD_COPY && ld_idx_r == 5'(i)) begin
        coef_mem[i] <= (i % DPC_COEF_PER_BQ == 0) ? DPC_COEF_UNITY
                                                  : DPC_COEF_ZERO;
      end else if (coef_wr_ok && coef_sel == 5'(i)) begin
        unique case (reg_addr[1:0])
          2'h0: coef_mem[i][23:16] <= reg_wdata;
          2'h1: coef_mem[i][15:8] <= reg_wdata;
          2'h2: coef_mem[i][7:0] <= reg_wdata;
          default: coef_mem[i] <= coef_mem[i];
        endcase
      end
    end
  end

  // Registered read port for the filter engine.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      coef_data <= DPC_COEF_ZERO;
    end else begin
      coef_data <= (coef_idx < 5'(DPC_NCOEF)) ? coef_mem[coef_idx]
                                              : DPC_COEF_ZERO;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register read mux; unmapped offsets read zero.
  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_addr == DPC_A_PAGE) begin
      rdata_nxt = page_r;
    end else if (pg_ctrl) begin
      unique case (reg_addr)
        DPC_A_STATUS: begin
          rdata_nxt[DPC_B_ST_SETTLED] = (hp_vol_code == vol_tgt);
          rdata_nxt[DPC_B_ST_LOADING] = coeff_loading;
        end
        DPC_A_FLAGS_A: rdata_nxt = flags_a_r;
        DPC_A_FLAGS_B: rdata_nxt = flags_b_r;
        DPC_A_IRQ1_CFG: rdata_nxt = irq1_cfg_r;
        DPC_A_IRQ2_CFG: rdata_nxt = irq2_cfg_r;
        DPC_A_GPIO_CTRL: rdata_nxt = gpio_ctrl_r;
        DPC_A_PATH_SETUP: rdata_nxt = path_r;
        default: rdata_nxt = 8'h00;
      endcase
    end else if (pg_analog) begin
      if (reg_addr == DPC_A_HP_ROUTE) rdata_nxt = hp_route_r;
      if (reg_addr == DPC_A_HP_VOL) rdata_nxt = hp_vol_r;
    end else if (pg_coef && reg_addr == DPC_A_COEF_CTRL) begin
      rdata_nxt = coef_ctrl_r;
    end else if (coef_hit) begin
      unique case (reg_addr[1:0])
        2'h0: rdata_nxt = coef_mem[coef_sel][23:16];
        2'h1: rdata_nxt = coef_mem[coef_sel][15:8];
        2'h2: rdata_nxt = coef_mem[coef_sel][7:0];
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  // Read data is held until the next read.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // First mixer: sign-extend before adding so the half sum cannot wrap.
  assign mix_sum = {left_sample[23], left_sample} +
                   {right_sample[23], right_sample};

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mono_sample <= 24'h000000;
    end else if (sample_tick) begin
      unique case (path_r[5:4])
        DPC_MIX_OFF: mono_sample <= 24'h000000;
        DPC_MIX_LEFT: mono_sample <= left_sample;
        DPC_MIX_RIGHT: mono_sample <= right_sample;
        DPC_MIX_HALF_SUM: mono_sample <= mix_sum[24:1];
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Internal step oscillator. Samples stop when the DAC is off, so the
  // volume ramp falls back to this divider and still completes.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      osc_cnt_r <= 12'h000;
    end else begin
      osc_cnt_r <= osc_tick ? 12'h000 : osc_cnt_r + 12'h001;
    end
  end

  assign osc_tick = (osc_cnt_r == DPC_VOL_OSC_CYC - 12'h001);
  assign step_src = dac_power ? sample_tick : osc_tick;

  // Half-rate divider for the slower pace.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      half_r <= 1'b0;
    end else if (step_src) begin
      half_r <= ~half_r;
    end
  end

  assign step_en = (path_r[1:0] == DPC_SS_EVERY) ? step_src :
                   (path_r[1:0] == DPC_SS_EVERY_TWO) ? (step_src & half_r)
                                                     : 1'b0;
  // Muting ramps to the deepest code before the mute takes hold.
  assign vol_tgt = hp_vol_r[DPC_B_HP_MUTE] ? DPC_VOL_MAX_CODE
                                           : hp_vol_r[6:0];

  // Soft-stepped current volume code.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hp_vol_code <= DPC_RST_VOL;
    end else if (soft_rst_r) begin
      hp_vol_code <= DPC_RST_VOL;
    end else if (path_r[1]) begin
      hp_vol_code <= vol_tgt; // Soft-stepping disabled.
    end else if (step_en && hp_vol_code < vol_tgt) begin
      hp_vol_code <= hp_vol_code + 7'h01;
    end else if (step_en && hp_vol_code > vol_tgt) begin
      hp_vol_code <= hp_vol_code - 7'h01;
    end
  end

  // Code to attenuation in tenths of dB.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hp_atten_tenths <= 10'h000;
    end else if (hp_vol_code < DPC_VOL_LIN_END) begin
      hp_atten_tenths <= 10'(hp_vol_code * DPC_VOL_LIN_STEP);
    end else if (hp_vol_code >= DPC_VOL_FLOOR_CODE) begin
      hp_atten_tenths <= DPC_VOL_FLOOR;
    end else begin
      hp_atten_tenths <= DPC_VOL_TAB[hp_vol_code - DPC_VOL_LIN_END];
    end
  end

  // Mute and headphone routing outputs.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hp_mute <= 1'b0;
      hp_mix_route <= 1'b0;
    end else begin
      hp_mute <= hp_vol_r[DPC_B_HP_MUTE] &&
                 hp_vol_code == DPC_VOL_MAX_CODE;
      hp_mix_route <= hp_route_r[DPC_B_HP_ROUTE];
    end
  end

endmodule // dpc_top

// ---- dpc_pkg.sv ----
// Package for the playback path control block: register map, fields,
// reset values and timing counts.
// Assumes a 100 MHz mclk and an 8-bit paged register port.
package dpc_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Register offsets. Offset 0 on every page is the page select.
  localparam logic [6:0] DPC_A_PAGE = 7'h00;
  localparam logic [6:0] DPC_A_SWRST = 7'h01;
  localparam logic [6:0] DPC_A_STATUS = 7'h26;
  localparam logic [6:0] DPC_A_FLAGS_A = 7'h2A;
  localparam logic [6:0] DPC_A_FLAGS_B = 7'h2C;
  localparam logic [6:0] DPC_A_IRQ1_CFG = 7'h30;
  localparam logic [6:0] DPC_A_IRQ2_CFG = 7'h31;
  localparam logic [6:0] DPC_A_GPIO_CTRL = 7'h33;
  localparam logic [6:0] DPC_A_PATH_SETUP = 7'h3F;
  localparam logic [6:0] DPC_A_HP_ROUTE = 7'h0C;
  localparam logic [6:0] DPC_A_HP_VOL = 7'h16;
  localparam logic [6:0] DPC_A_COEF_CTRL = 7'h01;
  localparam logic [6:0] DPC_A_COEF_BASE = 7'h08;

  // Pages.
  localparam logic [7:0] DPC_PG_CTRL = 8'h00;
  localparam logic [7:0] DPC_PG_ANALOG = 8'h01;
  localparam logic [7:0] DPC_PG_COEF_LO = 8'h08;
  localparam logic [7:0] DPC_PG_COEF_HI = 8'h0F;

  //////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int DPC_B_SWRST = 0;
  localparam int DPC_B_TRAIN = 0;
  localparam int DPC_B_EN_HP_OC = 7;
  localparam int DPC_B_EN_SPK_OC = 6;
  localparam int DPC_B_EN_DAC_OVF = 5;
  localparam int DPC_B_EN_FLT_OVF = 4;
  localparam int DPC_B_FL_SPK_OC = 7;
  localparam int DPC_B_FL_HP_OC = 6;
  localparam int DPC_B_FL_DAC_OVF = 6;
  localparam int DPC_B_FL_FLT_OVF = 5;
  localparam int DPC_B_HP_ROUTE = 2;
  localparam int DPC_B_HP_MUTE = 7;
  localparam int DPC_B_ADAPTIVE = 2;
  localparam int DPC_B_ST_SETTLED = 4;
  localparam int DPC_B_ST_LOADING = 0;

  // Mixer select values, field D5-D4 of the path setup register.
  localparam logic [1:0] DPC_MIX_OFF = 2'h0;
  localparam logic [1:0] DPC_MIX_LEFT = 2'h1;
  localparam logic [1:0] DPC_MIX_RIGHT = 2'h2;
  localparam logic [1:0] DPC_MIX_HALF_SUM = 2'h3;

  // Soft-step pace values, field D1-D0 of the path setup register.
  localparam logic [1:0] DPC_SS_EVERY = 2'h0;
  localparam logic [1:0] DPC_SS_EVERY_TWO = 2'h1;

  // GPIO source select values, field D1-D0 of the GPIO control register.
  localparam logic [1:0] DPC_GPIO_LOW = 2'h0;
  localparam logic [1:0] DPC_GPIO_IRQ1 = 2'h1;
  localparam logic [1:0] DPC_GPIO_IRQ2 = 2'h2;

  //////////////////////////////////////////////////////////////////////////
  // Reset values.
  localparam logic [7:0] DPC_RST_REG = 8'h00;
  localparam logic [6:0] DPC_RST_VOL = 7'h00;

  // Coefficient memory.
  localparam int DPC_NCOEF = 30;
  localparam int DPC_COEF_PER_BQ = 5;
  localparam logic [23:0] DPC_COEF_UNITY = 24'h7FFFFF;
  localparam logic [23:0] DPC_COEF_ZERO = 24'h000000;

  //////////////////////////////////////////////////////////////////////////
  // Timing.
  localparam int DPC_CLK_MHZ = 100;
  localparam int DPC_LOAD_TIME_US = 100;
  localparam int DPC_LOAD_CYC = DPC_LOAD_TIME_US * DPC_CLK_MHZ;
  localparam int DPC_IRQ_PULSE_CYC = 4;
  localparam int DPC_IRQ_PERIOD_CYC = 16;
  localparam logic [11:0] DPC_VOL_OSC_CYC = 12'h823;

  // Volume table: attenuation in tenths of dB.
  localparam logic [6:0] DPC_VOL_LIN_END = 7'h24;
  localparam logic [6:0] DPC_VOL_FLOOR_CODE = 7'h75;
  localparam logic [6:0] DPC_VOL_MAX_CODE = 7'h7F;
  localparam logic [9:0] DPC_VOL_LIN_STEP = 10'h005;
  localparam logic [9:0] DPC_VOL_FLOOR = 10'h30F;
  localparam logic [9:0] DPC_VOL_TAB [0:80] = '{
    10'd181, 10'd186, 10'd191, 10'd196, 10'd201, 10'd206, 10'd211, 10'd216,
    10'd221, 10'd226, 10'd231, 10'd236, 10'd241, 10'd246, 10'd251, 10'd256,
    10'd261, 10'd266, 10'd271, 10'd276, 10'd281, 10'd286, 10'd291, 10'd296,
    10'd301, 10'd306, 10'd311, 10'd316, 10'd321, 10'd326, 10'd331, 10'd336,
    10'd341, 10'd346, 10'd352, 10'd357, 10'd362, 10'd367, 10'd372, 10'd377,
    10'd382, 10'd387, 10'd392, 10'd397, 10'd402, 10'd407, 10'd412, 10'd417,
    10'd421, 10'd427, 10'd432, 10'd438, 10'd443, 10'd448, 10'd452, 10'd458,
    10'd462, 10'd467, 10'd474, 10'd479, 10'd482, 10'd487, 10'd493, 10'd500,
    10'd503, 10'd510, 10'd514, 10'd518, 10'd522, 10'd527, 10'd537, 10'd542,
    10'd553, 10'd567, 10'd583, 10'd602, 10'd627, 10'd643, 10'd662, 10'd687,
    10'd722};

  // Coefficient loader states.
  typedef enum logic [1:0] {DPC_LD_COPY, DPC_LD_WAIT, DPC_LD_IDLE} dpc_ld_t;

endpackage

// ---- dpc_irq_gen.sv ----
// Interrupt pulse generator for one host interrupt output.
// Assumes its pending level comes from sticky flags on the same clock.
module dpc_irq_gen
  import dpc_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Control.
  input wire logic train_mode,
  input wire logic pending,
  // Output.
  output logic irq
);

  //////////////////////////////////////////////////////////////////////////
  logic pend_r;
  logic [4:0] cnt_r;
  logic rise;

  // A new event is the rise of the pending level; a second event while
  // the first is still latched gives no new pulse.
  assign rise = pending & ~pend_r;

  // Pending history for edge detection.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pend_r <= 1'b0;
    end else begin
      pend_r <= pending;
    end
  end

  // Counter: remaining pulse cycles in single mode, phase in train mode.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 5'h00;
    end else if (!pending) begin
      cnt_r <= 5'h00; // Reading the flags ends a train at once.
    end else if (rise) begin
      cnt_r <= train_mode ? 5'h01 : 5'(DPC_IRQ_PULSE_CYC - 1);
    end else if (train_mode) begin
      cnt_r <= (cnt_r == 5'(DPC_IRQ_PERIOD_CYC - 1)) ? 5'h00 : cnt_r + 5'h01;
    end else if (cnt_r != 5'h00) begin
      cnt_r <= cnt_r - 5'h01;
    end
  end

  // Output flop: single pulse of fixed width, or a periodic train.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else if (!pending) begin
      irq <= 1'b0;
    end else if (rise) begin
      irq <= 1'b1;
    end else if (train_mode) begin
      irq <= (cnt_r < 5'(DPC_IRQ_PULSE_CYC));
    end else begin
      irq <= (cnt_r != 5'h00);
    end
  end

endmodule // dpc_irq_gen

// ---- dpc_top_props.sv ----
// Port-level assertions for dpc_top: pulse widths, volume map, holds.
// Assumes a bind from the bench and no software reset during the run.
module dpc_top_props #(parameter int LOAD_CYCLES = 64) (
  // Clock, reset and strobes.
  input wire logic mclk, rst_n, reg_wr, sample_tick,
  // Watched outputs.
  input wire logic first_host_irq, second_host_irq, coeff_loading,
  input wire logic hp_mute, hp_mix_route,
  input wire logic [23:0] mono_sample,
  input wire logic [6:0] hp_vol_code,
  input wire logic [9:0] hp_atten_tenths
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Each burst is four cycles high, also the head of a train.
  sequence s_burst(x);
    x[*4] ##1 !x;
  endsequence
  //////////////////////////////////////////////////////////////////////////
  AST_IRQ1_WIDTH: assert property ($rose(first_host_irq) |->
    s_burst(first_host_irq)) else $error("irq1 pulse width wrong");
  AST_IRQ2_WIDTH: assert property ($rose(second_host_irq) |->
    s_burst(second_host_irq)) else $error("irq2 pulse width wrong");
  AST_MIX_HOLD: assert property (!sample_tick |=> $stable(mono_sample))
    else $error("mixer output moved without a sample");
  AST_ATTEN_LIN: assert property (hp_vol_code <= 7'h23 |=>
    hp_atten_tenths == {3'h0, $past(hp_vol_code)} * 10'h005)
    else $error("linear attenuation wrong");
  AST_ATTEN_FLOOR: assert property (hp_vol_code >= 7'h75 |=>
    hp_atten_tenths == 10'h30F) else $error("floor attenuation wrong");
  AST_LOAD_DONE: assert property (!coeff_loading |=> !coeff_loading)
    else $error("boot load restarted without reset");
  AST_MUTE: assert property (hp_mute |-> hp_vol_code == 7'h7F ||
    $past(hp_vol_code) == 7'h7F) else $error("mute below full code");
  AST_ROUTE_HOLD: assert property (!reg_wr && !$past(reg_wr) |=>
    $stable(hp_mix_route))
    else $error("route bit moved without a write");
endmodule // dpc_top_props

// ---- dpc_host.sv ----
// Host processor model on the paged register port of dpc_top.
// Assumes the bench calls its tasks from one process at a time.
module dpc_host (
  input wire logic mclk,
  input wire logic coeff_loading,
  input wire logic [7:0] reg_rdata,
  output logic [6:0] reg_addr = 7'h00,
  output logic [7:0] reg_wdata = 8'h00,
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0
);
  //////////////////////////////////////////////////////////////////////////
  // One write; the strobe is seen at exactly one edge.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // One read; the registered answer is taken after it has landed.
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    d = reg_rdata;
  endtask
  // Coefficient pages are left alone until the boot load ends.
  task automatic wait_load();
    for (int i = 0; i < 1000 && coeff_loading; i++) @(posedge mclk);
  endtask
endmodule // dpc_host

// ---- dac_path_control_tb.sv ----
// Bench for dpc_top: boot load, then mixer and volume rows, ramp and irqs.
// Assumes dpc_host drives the register port; converter starts off.
module dac_path_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dpc_pkg::*;
  typedef struct {logic [1:0] sel; logic [7:0] vol; logic [23:0] mono;
    logic [9:0] att; logic mute;} dpc_row_t;
  dpc_row_t rows [4] = '{'{2'h0, 8'h00, 24'h000000, 10'h000, 1'b0},
    '{2'h1, 8'h23, 24'h000100, 10'h0AF, 1'b0},
    '{2'h2, 8'h24, 24'h000300, 10'h0B5, 1'b0},
    '{2'h3, 8'hFF, 24'h000200, 10'h30F, 1'b1}};
  logic mclk = 1'b0, rst_n = 1'b0, hp_oc = 1'b0, dac_ovf = 1'b0;
  logic tick = 1'b0, dpow = 1'b0, wr, rd, irq1, irq2, loading, mute;
  logic route, gpio;
  logic [4:0] idx = 5'h05;
  logic [6:0] addr, code;
  logic [7:0] wdata, rdata, got;
  logic [9:0] atten;
  logic [23:0] mono, cdata;
  int n_fail = 0, check_count = 0, cyc = 0;
  dpc_top #(.LOAD_CYCLES(64)) dut (.mclk(mclk), .rst_n(rst_n),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdata), .hp_overcurrent(hp_oc), .spk_overcurrent(1'b0),
    .dac_overflow(dac_ovf), .filter_overflow(1'b0), .dac_power(dpow),
    .sample_tick(tick), .left_sample(24'h000100),
    .right_sample(24'h000300), .mono_sample(mono), .coef_idx(idx),
    .coef_data(cdata), .coeff_loading(loading), .first_host_irq(irq1),
    .second_host_irq(irq2), .gpio_out(gpio), .hp_vol_code(code),
    .hp_atten_tenths(atten), .hp_mute(mute), .hp_mix_route(route));
  dpc_host host (.mclk(mclk), .coeff_loading(loading), .reg_rdata(rdata),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd));
  //////////////////////////////////////////////////////////////////////////
  // Compare one value and report a mismatch at once.
  task automatic chk(input string what, input logic [23:0] exp, seen);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    if (n_fail == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Clock, and a cycle ceiling well above the few hundred cycles needed.
  initial forever #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // Main sequence; the converter is powered only once configured.
  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    chk("loading", 24'h000001, 24'(loading));
    host.wait_load();
    @(negedge mclk);
    chk("loaded", 24'h000000, 24'(loading));
    chk("coef5", DPC_COEF_UNITY, cdata);
    // Low byte of entry 5, written while the converter is still off.
    host.wr(DPC_A_PAGE, DPC_PG_COEF_LO);
    host.wr(DPC_A_COEF_BASE + 7'h16, 8'h5A);
    host.rd(DPC_A_COEF_BASE + 7'h16, got);
    chk("coef rd", 24'h00005A, 24'(got));
    chk("coef5 new", {DPC_COEF_UNITY[23:8], 8'h5A}, cdata);
    foreach (rows[i]) begin
      host.wr(DPC_A_PAGE, DPC_PG_CTRL);
      host.wr(DPC_A_PATH_SETUP, {2'h0, rows[i].sel, 4'h2});
      host.wr(DPC_A_PAGE, DPC_PG_ANALOG);
      host.wr(DPC_A_HP_VOL, rows[i].vol);
      host.wr(DPC_A_HP_ROUTE, {5'h00, rows[i].mute, 2'h0});
      @(posedge mclk) tick <= 1'b1;
      @(posedge mclk) tick <= 1'b0;
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      chk("mono", rows[i].mono, mono);
      chk("code", 24'(rows[i].vol[6:0]), 24'(code));
      chk("atten", 24'(rows[i].att), 24'(atten));
      chk("mute", 24'(rows[i].mute), 24'(mute));
      chk("route", 24'(rows[i].mute), 24'(route));
    end
    // Ramp from the muted code: one step per sample once powered.
    host.wr(DPC_A_PAGE, DPC_PG_CTRL);
    host.wr(DPC_A_PATH_SETUP,
      {2'h0, DPC_MIX_HALF_SUM, 2'h0, DPC_SS_EVERY});
    dpow <= 1'b1; // No coefficient changes in play.
    host.wr(DPC_A_PAGE, DPC_PG_ANALOG);
    host.wr(DPC_A_HP_VOL, 8'h7D);
    @(posedge mclk) tick <= 1'b1;
    @(posedge mclk) tick <= 1'b0;
    @(negedge mclk);
    chk("ramp", 24'h00007E, 24'(code));
    host.wr(DPC_A_PAGE, DPC_PG_CTRL);
    host.wr(DPC_A_IRQ1_CFG, 8'h80);
    host.wr(DPC_A_IRQ2_CFG, 8'h21);
    host.wr(DPC_A_GPIO_CTRL, {6'h00, DPC_GPIO_IRQ2});
    @(posedge mclk) hp_oc <= 1'b1;
    dac_ovf <= 1'b1;
    @(posedge mclk) hp_oc <= 1'b0;
    dac_ovf <= 1'b0;
    @(posedge mclk);
    @(negedge mclk);
    chk("irq1", 24'h000001, 24'(irq1));
    chk("irq2", 24'h000001, 24'(irq2));
    @(negedge mclk);
    chk("gpio", 24'h000001, 24'(gpio));
    repeat (16) @(posedge mclk);
    @(negedge mclk);
    chk("irq1 again", 24'h000000, 24'(irq1));
    chk("irq2 train", 24'h000001, 24'(irq2));
    repeat (6) @(posedge mclk);
    host.rd(DPC_A_FLAGS_B, got);
    chk("flags b", 24'h000040, 24'(got));
    host.rd(DPC_A_FLAGS_A, got);
    chk("flags a", 24'h000040, 24'(got));
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    chk("irq2 stop", 24'h000000, 24'(irq2));
    tally_and_finish();
  end
endmodule // dac_path_control_tb
bind dpc_top dpc_top_props #(.LOAD_CYCLES(LOAD_CYCLES)) u_props (
  .mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr), .sample_tick(sample_tick),
  .first_host_irq(first_host_irq), .second_host_irq(second_host_irq),
  .coeff_loading(coeff_loading), .hp_mute(hp_mute),
  .hp_mix_route(hp_mix_route), .mono_sample(mono_sample),
  .hp_vol_code(hp_vol_code), .hp_atten_tenths(hp_atten_tenths));
